// ===== tpwm_top.sv
// 16-bit timer with clear-on-match, fast PWM and phase correct PWM waveforms.
// Assumes a single AHB-Lite master, zero-wait writes, and hclk as the I/O clock.
//
// Notes on behaviour
// - Modes 4 and 12 clear the counter when it equals compare A or capture value.
// - In clear-on-match modes the TOP register's flag sets when the counter reaches TOP.
// - Clear-on-match TOP writes act at once; a missed match wraps through zero.
// - Clear-on-match with action 1 toggles waveform A on every match.
// - Waveform A drives its pin only while its direction bit is one.
// - Clear-on-match sets the overflow flag when the counter rolls from max to zero.
// - Modes 5, 6, 7, 14, 15 count single slope from bottom to TOP.
// - Fast TOP is 0x00FF, 0x01FF, 0x03FF, capture value or compare A.
// - Fast action 2 sets on match, clears at TOP; action 3 inverts that.
// - Fast mode sets overflow at TOP, plus compare A or capture flag when defining TOP.
// - Fixed-TOP modes mask compare writes above the fixed resolution to zero.
// - Capture value as TOP is unbuffered; a missed match runs to 0xFFFF first.
// - Fast PWM compare writes land in a buffer loaded at TOP.
// - Fast compare zero gives a spike; compare equal TOP gives a constant level.
// - Fast action 1 toggles waveform A, only in mode 15.
// - Timer clock prescale is 1, 8, 64, 256 or 1024.
// - Fast PWM period is N times TOP plus one clocks.
// - Modes 1, 2, 3, 10, 11 count dual slope with up and down match actions.
// - Action 0 leaves the waveform unchanged at matches.
// - Phase correct sets overflow at bottom and holds TOP one tick.
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "tpwm_defines.svh"
module tpwm_top
    import tpwm_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Waveform pins
    output logic wave_a_out,
    output logic wave_a_oe,
    output logic wave_b_out,
    output logic wave_b_oe
);
    localparam int NCH = 2;

    tpwm_tick_if tk ();

    // Bus state
    logic wr_pend_ff;
    logic rd_pend_ff;
    logic rd_done_ff;
    logic [7:0] addr_ff;
    logic [31:0] hrdata_ff;
    logic addr_take;

    // Software-visible state
    logic [`TPWM_CTRL_W-1:0] ctrl_ff;
    logic [15:0] buf_ff [NCH];
    logic [15:0] act_ff [NCH];
    logic [15:0] capt_ff;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [`TPWM_FLG_W-1:0] flag_ff;
    logic [`TPWM_FLG_W-1:0] flag_set;
    tpwm_dir_t dir_ff;
    tpwm_dir_t nxt_dir;
    logic [NCH-1:0] wave_ff;

    // Decoded control
    logic [3:0] mode;
    logic [1:0] act [NCH];
    tpwm_kind_t kind;
    logic [15:0] top;
    logic at_top;
    logic reload;
    logic cnt_wr;
    logic [15:0] wdata16;

    function automatic tpwm_kind_t kind_of(input logic [3:0] m);
        unique case (m)
            `TPWM_M_CTC_A, `TPWM_M_CTC_CAP: kind_of = K_CTC;
            `TPWM_M_FP8, `TPWM_M_FP9, `TPWM_M_FP10, `TPWM_M_FP_CAP, `TPWM_M_FP_A:
                kind_of = K_FAST;
            `TPWM_M_PC8, `TPWM_M_PC9, `TPWM_M_PC10, `TPWM_M_PC_CAP, `TPWM_M_PC_A:
                kind_of = K_PHASE;
            default: kind_of = K_NORMAL;
        endcase
    endfunction

    // Mask of the fixed resolution; full width where TOP is not fixed
    function automatic logic [15:0] fixed_mask(input logic [3:0] m);
        unique case (m)
            `TPWM_M_PC8, `TPWM_M_FP8: fixed_mask = `TPWM_TOP8;
            `TPWM_M_PC9, `TPWM_M_FP9: fixed_mask = `TPWM_TOP9;
            `TPWM_M_PC10, `TPWM_M_FP10: fixed_mask = `TPWM_TOP10;
            default: fixed_mask = `TPWM_MAX;
        endcase
    endfunction

    function automatic logic top_is_cap(input logic [3:0] m);
        top_is_cap = (m == `TPWM_M_CTC_CAP) || (m == `TPWM_M_FP_CAP) || (m == `TPWM_M_PC_CAP);
    endfunction

    function automatic logic top_is_a(input logic [3:0] m);
        top_is_a = (m == `TPWM_M_CTC_A) || (m == `TPWM_M_FP_A) || (m == `TPWM_M_PC_A);
    endfunction

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
        is_reg = (a == ofs);
    endfunction

    assign mode = ctrl_ff[`TPWM_CTRL_MODE_MSB:`TPWM_CTRL_MODE_LSB];
    assign act[0] = ctrl_ff[`TPWM_CTRL_ACTA_MSB:`TPWM_CTRL_ACTA_LSB];
    assign act[1] = ctrl_ff[`TPWM_CTRL_ACTB_MSB:`TPWM_CTRL_ACTB_LSB];
    assign kind = kind_of(mode);
    assign tk.clk_sel = ctrl_ff[`TPWM_CTRL_CSEL_MSB:`TPWM_CTRL_CSEL_LSB];

    tpwm_prescaler u_presc (
        .hclk(hclk),
        .hresetn(hresetn),
        .tk(tk)
    );

    // TOP selection; active compare A is used so the buffer never shifts TOP early
    always_comb begin
        if (top_is_a(mode)) begin
            top = act_ff[0];
        end else if (top_is_cap(mode)) begin
            top = capt_ff;
        end else if (kind == K_NORMAL) begin
            top = `TPWM_MAX;
        end else begin
            top = fixed_mask(mode);
        end
    end

    assign at_top = (cnt_ff == top);
    // Buffered compare values move over at TOP in both PWM kinds
    assign reload = tk.tick && at_top && ((kind == K_FAST) || (kind == K_PHASE));

    // Bus: writes land at the end of a one-cycle data phase; reads take one wait state
    // so that a read right after a write returns the new value.
    assign addr_take = hsel && htrans[1] && hready;
    assign hreadyout = !(rd_pend_ff && !rd_done_ff);
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign wdata16 = hwdata[15:0];
    assign cnt_wr = wr_pend_ff && is_reg(addr_ff, `TPWM_OFS_CNT);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            rd_done_ff <= 1'b0;
            addr_ff <= 8'h00;
        end else begin
            if (hreadyout) begin
                wr_pend_ff <= addr_take && hwrite;
                rd_pend_ff <= addr_take && !hwrite;
                addr_ff <= addr_take ? haddr : addr_ff;
                rd_done_ff <= 1'b0;
            end else begin
                rd_done_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_pend_ff && !rd_done_ff) begin
            unique case (addr_ff)
                `TPWM_OFS_CTRL: hrdata_ff <= {19'h00000, ctrl_ff};
                `TPWM_OFS_CMPA: hrdata_ff <= {16'h0000, buf_ff[0]};
                `TPWM_OFS_CMPB: hrdata_ff <= {16'h0000, buf_ff[1]};
                `TPWM_OFS_CAPT: hrdata_ff <= {16'h0000, capt_ff};
                `TPWM_OFS_CNT: hrdata_ff <= {16'h0000, cnt_ff};
                `TPWM_OFS_FLAG: hrdata_ff <= {28'h0000000, flag_ff};
                default: hrdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= `TPWM_CTRL_RST;
        end else if (wr_pend_ff && is_reg(addr_ff, `TPWM_OFS_CTRL)) begin
            ctrl_ff <= hwdata[`TPWM_CTRL_W-1:0];
        end
    end

    // Capture value has no buffer, so a TOP below the count is missed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capt_ff <= `TPWM_WORD_RST;
        end else if (wr_pend_ff && is_reg(addr_ff, `TPWM_OFS_CAPT)) begin
            capt_ff <= wdata16;
        end
    end

    // Compare registers: buffer plus active copy per channel
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_cmp
            localparam logic [7:0] OFS = (c == 0) ? `TPWM_OFS_CMPA : `TPWM_OFS_CMPB;
            logic cmp_wr;
            assign cmp_wr = wr_pend_ff && is_reg(addr_ff, OFS);

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    buf_ff[c] <= `TPWM_WORD_RST;
                end else if (cmp_wr) begin
                    buf_ff[c] <= wdata16 & fixed_mask(mode);
                end
            end

            // Non-PWM kinds write straight through; a lowered TOP then wraps
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    act_ff[c] <= `TPWM_WORD_RST;
                end else if (cmp_wr && (kind == K_NORMAL || kind == K_CTC)) begin
                    act_ff[c] <= wdata16 & fixed_mask(mode);
                end else if (reload) begin
                    act_ff[c] <= buf_ff[c];
                end
            end
        end
    endgenerate

    // Counter sequencing
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_dir = dir_ff;
        flag_set = '0;
        if (tk.tick) begin
            unique case (kind)
                K_FAST: begin
                    nxt_cnt = at_top ? `TPWM_BOTTOM : cnt_ff + 16'h0001;
                    flag_set[`TPWM_FLG_OVF] = at_top;
                    flag_set[`TPWM_FLG_CAPT] = at_top && top_is_cap(mode);
                    nxt_dir = DIR_UP;
                end
                K_CTC: begin
                    nxt_cnt = at_top ? `TPWM_BOTTOM : cnt_ff + 16'h0001;
                    flag_set[`TPWM_FLG_OVF] = !at_top && (cnt_ff == `TPWM_MAX);
                    flag_set[`TPWM_FLG_CAPT] = at_top && top_is_cap(mode);
                    nxt_dir = DIR_UP;
                end
                K_PHASE: begin
                    // TOP shows for one tick, then the count turns down
                    if (dir_ff == DIR_UP && at_top) begin
                        nxt_dir = DIR_DOWN;
                        nxt_cnt = cnt_ff - 16'h0001;
                        flag_set[`TPWM_FLG_CAPT] = top_is_cap(mode);
                    end else if (dir_ff == DIR_DOWN && cnt_ff == `TPWM_BOTTOM) begin
                        nxt_dir = DIR_UP;
                        nxt_cnt = cnt_ff + 16'h0001;
                    end else if (dir_ff == DIR_DOWN) begin
                        nxt_cnt = cnt_ff - 16'h0001;
                        flag_set[`TPWM_FLG_OVF] = (cnt_ff == 16'h0001);
                    end else begin
                        nxt_cnt = cnt_ff + 16'h0001;
                    end
                end
                default: begin
                    nxt_cnt = cnt_ff + 16'h0001;
                    flag_set[`TPWM_FLG_OVF] = (cnt_ff == `TPWM_MAX);
                    nxt_dir = DIR_UP;
                end
            endcase
            flag_set[`TPWM_FLG_CMPA] = (cnt_ff == act_ff[0]);
            flag_set[`TPWM_FLG_CMPB] = (cnt_ff == act_ff[1]);
        end
    end

    // A software write to the counter takes priority over counting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= `TPWM_BOTTOM;
            dir_ff <= DIR_UP;
        end else begin
            cnt_ff <= cnt_wr ? wdata16 : nxt_cnt;
            dir_ff <= nxt_dir;
        end
    end

    // Write one to clear; a flag set in the same cycle survives the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_ff <= '0;
        end else if (wr_pend_ff && is_reg(addr_ff, `TPWM_OFS_FLAG)) begin
            flag_ff <= (flag_ff & ~hwdata[`TPWM_FLG_W-1:0]) | flag_set;
        end else begin
            flag_ff <= flag_ff | flag_set;
        end
    end

    // Waveform registers, one per channel
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_wave
            logic match;
            logic tgl_ok;
            logic nxt_wave;
            assign match = tk.tick && (cnt_ff == act_ff[c]);
            // Toggle in PWM kinds only on channel A with compare A as TOP
            assign tgl_ok = (c == 0) && (mode == `TPWM_M_FP_A || mode == `TPWM_M_PC_A);

            always_comb begin
                nxt_wave = wave_ff[c];
                if (act[c] != `TPWM_ACT_NONE) begin
                    unique case (kind)
                        K_FAST: begin
                            if (act[c] == `TPWM_ACT_TGL) begin
                                nxt_wave = (match && tgl_ok) ? !wave_ff[c] : wave_ff[c];
                            end else if (match) begin
                                // Match wins over TOP so compare equal TOP holds steady
                                nxt_wave = (act[c] == `TPWM_ACT_CLR);
                            end else if (tk.tick && at_top) begin
                                nxt_wave = (act[c] == `TPWM_ACT_SET);
                            end
                        end
                        K_PHASE: begin
                            if (act[c] == `TPWM_ACT_TGL) begin
                                nxt_wave = (match && tgl_ok) ? !wave_ff[c] : wave_ff[c];
                            end else if (match) begin
                                nxt_wave = (dir_ff == DIR_UP) ^ (act[c] == `TPWM_ACT_CLR);
                            end
                        end
                        default: begin
                            if (match) begin
                                unique case (act[c])
                                    `TPWM_ACT_TGL: nxt_wave = !wave_ff[c];
                                    `TPWM_ACT_CLR: nxt_wave = 1'b0;
                                    default: nxt_wave = 1'b1;
                                endcase
                            end
                        end
                    endcase
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    wave_ff[c] <= 1'b0;
                end else begin
                    wave_ff[c] <= nxt_wave;
                end
            end
        end
    endgenerate

    // Pins show the waveform only with an action selected; port data is not modelled
    assign wave_a_out = wave_ff[0] && (act[0] != `TPWM_ACT_NONE);
    assign wave_a_oe = ctrl_ff[`TPWM_CTRL_DIRA];
    assign wave_b_out = wave_ff[1] && (act[1] != `TPWM_ACT_NONE);
    assign wave_b_oe = ctrl_ff[`TPWM_CTRL_DIRB];

    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, hwdata[31:16]};
endmodule

// ===== tpwm_defines.svh
// Register map, field positions, reset values and timing constants of the PWM timer.
// Assumes inclusion by bare name from the design files.
`ifndef TPWM_DEFINES_SVH
`define TPWM_DEFINES_SVH

// Byte offsets on the register bus
`define TPWM_OFS_CTRL 8'h00
`define TPWM_OFS_CMPA 8'h04
`define TPWM_OFS_CMPB 8'h08
`define TPWM_OFS_CAPT 8'h0C
`define TPWM_OFS_CNT 8'h10
`define TPWM_OFS_FLAG 8'h14

// Control register fields
`define TPWM_CTRL_MODE_LSB 0
`define TPWM_CTRL_MODE_MSB 3
`define TPWM_CTRL_ACTA_LSB 4
`define TPWM_CTRL_ACTA_MSB 5
`define TPWM_CTRL_ACTB_LSB 6
`define TPWM_CTRL_ACTB_MSB 7
`define TPWM_CTRL_CSEL_LSB 8
`define TPWM_CTRL_CSEL_MSB 10
`define TPWM_CTRL_DIRA 11
`define TPWM_CTRL_DIRB 12
`define TPWM_CTRL_W 13

// Flag register bits
`define TPWM_FLG_OVF 0
`define TPWM_FLG_CMPA 1
`define TPWM_FLG_CMPB 2
`define TPWM_FLG_CAPT 3
`define TPWM_FLG_W 4

// Waveform mode codes
`define TPWM_M_NORMAL 4'h0
`define TPWM_M_PC8 4'h1
`define TPWM_M_PC9 4'h2
`define TPWM_M_PC10 4'h3
`define TPWM_M_CTC_A 4'h4
`define TPWM_M_FP8 4'h5
`define TPWM_M_FP9 4'h6
`define TPWM_M_FP10 4'h7
`define TPWM_M_PC_CAP 4'hA
`define TPWM_M_PC_A 4'hB
`define TPWM_M_CTC_CAP 4'hC
`define TPWM_M_FP_CAP 4'hE
`define TPWM_M_FP_A 4'hF

// Output actions
`define TPWM_ACT_NONE 2'h0
`define TPWM_ACT_TGL 2'h1
`define TPWM_ACT_CLR 2'h2
`define TPWM_ACT_SET 2'h3

// Counter limits
`define TPWM_BOTTOM 16'h0000
`define TPWM_MAX 16'hFFFF
`define TPWM_TOP8 16'h00FF
`define TPWM_TOP9 16'h01FF
`define TPWM_TOP10 16'h03FF

// Prescaler select codes and divider end counts, each the divisor minus one
`define TPWM_CS_STOP 3'h0
`define TPWM_CS_1 3'h1
`define TPWM_CS_8 3'h2
`define TPWM_CS_64 3'h3
`define TPWM_CS_256 3'h4
`define TPWM_CS_1024 3'h5
`define TPWM_DIV_1 10'h000
`define TPWM_DIV_8 10'h007
`define TPWM_DIV_64 10'h03F
`define TPWM_DIV_256 10'h0FF
`define TPWM_DIV_1024 10'h3FF

`define TPWM_CTRL_RST 13'h0000
`define TPWM_WORD_RST 16'h0000
`endif

// ===== tpwm_pkg.sv
// Types shared by the PWM timer modules.
// Assumes tpwm_defines.svh supplies every numeric constant.
package tpwm_pkg;
    typedef enum logic [3:0] {
        K_NORMAL = 4'b0001,
        K_CTC = 4'b0010,
        K_FAST = 4'b0100,
        K_PHASE = 4'b1000
    } tpwm_kind_t;

    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } tpwm_dir_t;
endpackage

// ===== tpwm_tick_if.sv
// Carrier between the register block and the timer clock prescaler.
// Assumes both ends run on the bus clock.
`timescale 1ns/1ps
interface tpwm_tick_if;
    logic [2:0] clk_sel;
    logic tick;
    modport src (input clk_sel, output tick);
    modport sink (output clk_sel, input tick);
endinterface

// ===== tpwm_prescaler.sv
// Timer clock prescaler: one-cycle tick every N bus clocks, N chosen by clk_sel.
// Assumes clk_sel is driven from a register on the same clock.
`timescale 1ns/1ps
`include "tpwm_defines.svh"
module tpwm_prescaler
    import tpwm_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Tick carrier
    tpwm_tick_if.src tk
);
    logic [9:0] div_cnt_ff;
    logic [9:0] nxt_div_cnt;
    logic [9:0] div_last;
    logic [2:0] sel_ff;
    logic tick_ff;

    always_comb begin
        unique case (tk.clk_sel)
            `TPWM_CS_1: div_last = `TPWM_DIV_1;
            `TPWM_CS_8: div_last = `TPWM_DIV_8;
            `TPWM_CS_64: div_last = `TPWM_DIV_64;
            `TPWM_CS_256: div_last = `TPWM_DIV_256;
            default: div_last = `TPWM_DIV_1024;
        endcase
    end

    // A changed selection restarts the divider so the first period is whole
    always_comb begin
        if (tk.clk_sel != sel_ff || div_cnt_ff >= div_last) begin
            nxt_div_cnt = 10'h000;
        end else begin
            nxt_div_cnt = div_cnt_ff + 10'h001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_ff <= 10'h000;
            sel_ff <= `TPWM_CS_STOP;
            tick_ff <= 1'b0;
        end else begin
            sel_ff <= tk.clk_sel;
            div_cnt_ff <= nxt_div_cnt;
            tick_ff <= (tk.clk_sel != `TPWM_CS_STOP) && (tk.clk_sel == sel_ff)
                && (div_cnt_ff >= div_last);
        end
    end

    assign tk.tick = tick_ff;
endmodule

// ===== tpwm_asserts.sv
// Checker on the timer's bus and pin ports.
// Assumes one master with hready looped back from hreadyout.
`timescale 1ns/1ps
module tpwm_asserts (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Pins
    input wire logic wave_a_out,
    input wire logic wave_a_oe,
    input wire logic wave_b_out,
    input wire logic wave_b_oe
);
    logic take;
    logic wr_ctl_ff;
    logic [12:0] ctl_ff;
    assign take = hsel && htrans[1] && hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_ctl_ff <= 1'b0;
        else if (hready) wr_ctl_ff <= take && hwrite && haddr == 8'h00;
    end
    // Shadow of the control word, taken from the bus alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) ctl_ff <= 13'h0000;
        else if (wr_ctl_ff) ctl_ff <= hwdata[12:0];
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("response not OKAY");
    AST_RD_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_WR_ZERO: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    AST_CTL_READ: assert property (take && !hwrite && haddr == 8'h00
        |-> ##2 hrdata == {19'h00000, ctl_ff})
        else $error("control readback wrong");
    AST_OE_A: assert property (wave_a_oe == ctl_ff[11])
        else $error("pin A enable wrong");
    AST_OE_B: assert property (wave_b_oe == ctl_ff[12])
        else $error("pin B enable wrong");
    AST_IDLE_A: assert property (ctl_ff[5:4] == 2'h0 |-> !wave_a_out)
        else $error("waveform A active with no action");
    AST_IDLE_B: assert property (ctl_ff[7:6] == 2'h0 |-> !wave_b_out)
        else $error("waveform B active with no action");
endmodule
bind tpwm_top tpwm_asserts chk_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .wave_a_out, .wave_a_oe, .wave_b_out, .wave_b_oe
);

// ===== tb.sv
// Self-checking bench for the PWM timer top.
// Assumes a single bus master, with hready looped back from hreadyout.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [3:0] md;
        logic [1:0] act;
        logic [2:0] cs;
        logic [7:0] cmp;
        logic [7:0] cap;
        logic [15:0] win;
        logic [15:0] hi;
        logic [3:0] flg;
    } tpwm_row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic wave_a_out;
    logic wave_a_oe;
    logic wave_b_out;
    logic wave_b_oe;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] rv;
    tpwm_row_t r;
    // Windows span two periods, so the high count does not depend on phase
    tpwm_row_t rows [17] = '{
        '{4'hF, 2'h2, 3'h1, 8'h03, 8'h00, 16'h0008, 16'h0008, 4'h3},
        '{4'hF, 2'h1, 3'h1, 8'h03, 8'h00, 16'h0010, 16'h0008, 4'h3},
        '{4'hE, 2'h2, 3'h1, 8'h02, 8'h07, 16'h0010, 16'h000A, 4'hB},
        '{4'hE, 2'h3, 3'h1, 8'h02, 8'h07, 16'h0010, 16'h0006, 4'hB},
        '{4'hE, 2'h2, 3'h1, 8'h00, 8'h07, 16'h0010, 16'h000E, 4'hB},
        '{4'hE, 2'h3, 3'h1, 8'h07, 8'h07, 16'h0010, 16'h0000, 4'hB},
        '{4'h5, 2'h2, 3'h1, 8'h10, 8'h00, 16'h0200, 16'h01DE, 4'h3},
        '{4'h6, 2'h2, 3'h1, 8'h10, 8'h00, 16'h0400, 16'h03DE, 4'h3},
        '{4'h7, 2'h2, 3'h1, 8'h10, 8'h00, 16'h0800, 16'h07DE, 4'h3},
        '{4'h4, 2'h1, 3'h1, 8'h04, 8'h00, 16'h0014, 16'h000A, 4'h2},
        '{4'hC, 2'h1, 3'h1, 8'h02, 8'h05, 16'h0018, 16'h000C, 4'hA},
        '{4'hA, 2'h2, 3'h1, 8'h02, 8'h07, 16'h001C, 16'h0008, 4'hB},
        '{4'hE, 2'h2, 3'h1, 8'h01, 8'h03, 16'h0008, 16'h0004, 4'hB},
        '{4'hE, 2'h2, 3'h2, 8'h01, 8'h03, 16'h0040, 16'h0020, 4'hB},
        '{4'hE, 2'h2, 3'h3, 8'h01, 8'h03, 16'h0200, 16'h0100, 4'hB},
        '{4'hE, 2'h2, 3'h4, 8'h01, 8'h03, 16'h0800, 16'h0400, 4'hB},
        '{4'hE, 2'h2, 3'h5, 8'h01, 8'h03, 16'h2000, 16'h1000, 4'hB}
    };
    always #25 hclk = ~hclk;
    tpwm_top dut_u (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .wave_a_out, .wave_a_oe,
        .wave_b_out, .wave_b_oe
    );
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // An unknown level poisons the sum, so it cannot pass as a match
    task automatic meas(input logic [15:0] n, input logic ch);
        rv = 32'h0000_0000;
        repeat (n) begin
            @(posedge hclk);
            rv = rv + {31'h0000_0000, ch ? wave_b_out : wave_a_out};
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            // Stop in normal mode first so compare writes land at once
            bus(1'b1, 8'h00, 32'h0000_0800);
            bus(1'b1, 8'h10, 32'h0000_0000);
            bus(1'b1, 8'h04, {24'h000000, r.cmp});
            bus(1'b1, 8'h0C, {24'h000000, r.cap});
            bus(1'b1, 8'h14, 32'h0000_000F);
            bus(1'b1, 8'h00, {20'h00000, 1'b1, r.cs, 2'h0, r.act, r.md});
            meas(r.win, 1'b0);
            meas(r.win, 1'b0);
            chk(rv, {16'h0000, r.hi});
            chk({31'h0000_0000, wave_a_oe}, 32'h0000_0001);
            bus(1'b0, 8'h14, 32'h0000_0000);
            chk(rv & 32'h0000_000B, {28'h0000000, r.flg});
            $display("row %0d done", i);
        end
        // Channel B alone: action 2 on a capture TOP of 3, pin A released
        bus(1'b1, 8'h00, 32'h0000_0800);
        bus(1'b1, 8'h10, 32'h0000_0000);
        bus(1'b1, 8'h08, 32'h0000_0001);
        bus(1'b1, 8'h0C, 32'h0000_0003);
        bus(1'b1, 8'h14, 32'h0000_000F);
        bus(1'b1, 8'h00, 32'h0000_118E);
        meas(16'h0008, 1'b1);
        meas(16'h0008, 1'b1);
        chk(rv, 32'h0000_0004);
        chk({30'h0000_0000, wave_b_oe, wave_a_oe}, 32'h0000_0002);
        chk({31'h0000_0000, wave_a_out}, 32'h0000_0000);
        bus(1'b0, 8'h14, 32'h0000_0000);
        chk(rv, 32'h0000_000F);
        $display("channel b done");
        // Fast fixed modes first, then the phase correct fixed modes
        for (int k = 0; k < 6; k++) begin
            bus(1'b1, 8'h00, (k < 3) ? 32'h0000_0005 + k : k - 2);
            bus(1'b1, 8'h04, 32'h0000_FFFF);
            bus(1'b1, 8'h08, 32'h0000_FFFF);
            bus(1'b0, 8'h04, 32'h0000_0000);
            chk(rv, (32'h0000_0100 << (k % 3)) - 32'h0000_0001);
            bus(1'b0, 8'h08, 32'h0000_0000);
            chk(rv, (32'h0000_0100 << (k % 3)) - 32'h0000_0001);
        end
        $display("masking done");
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, 8'h00, 32'h0000_0000);
            bus(1'b1, 8'h04, 32'h0000_0010);
            bus(1'b1, 8'h0C, 32'h0000_0010);
            bus(1'b1, 8'h10, 32'h0000_FFF0);
            bus(1'b1, 8'h14, 32'h0000_000F);
            bus(1'b1, 8'h00, (k == 0) ? 32'h0000_0104 : 32'h0000_010E);
            bus(1'b0, 8'h14, 32'h0000_0000);
            chk(rv & 32'h0000_000B, 32'h0000_0000);
            repeat (40) @(posedge hclk);
            bus(1'b0, 8'h14, 32'h0000_0000);
            chk(rv & 32'h0000_000B, (k == 0) ? 32'h0000_0003 : 32'h0000_000B);
            chk({31'h0000_0000, wave_a_out}, 32'h0000_0000);
        end
        $display("missed top done");
        bus(1'b1, 8'h00, 32'h0000_092F);
        repeat (40) @(posedge hclk);
        chk({30'h0000_0000, wave_a_out, wave_a_oe}, 32'h0000_0003);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({30'h0000_0000, wave_a_out, wave_a_oe}, 32'h0000_0000);
        hresetn <= 1'b1;
        bus(1'b1, 8'h18, 32'hFFFF_FFFF);
        for (int k = 0; k < 7; k++) begin
            bus(1'b0, {k[5:0], 2'b00}, 32'h0000_0000);
            chk(rv, 32'h0000_0000);
        end
        $display("reset done");
        close_out();
    end
endmodule
